// ==== verilog/owc_top.sv ====
`timescale 1ns/100ps
`include "owc_map.svh"
// Summary of operation
// - two byte counters cascade into 16-bit up-counter
// - match uses only upper compare byte
// - run bit three starts count from zero
// - match clears counter and raises interrupt
// - fs source gives 256 ticks per step
// - fc source gives 256 ticks per step
// - system control bits seven, six, five
// - mode codes select warm-up and cascading
module owc_top #(
   parameter int FC_CYC = `OWC_FC_CYC,
   parameter int FS_CYC = `OWC_FS_CYC
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic irq_out,
   output logic warmup_match_irq_out,
   output logic hf_osc_en_out,
   output logic lf_osc_en_out,
   output logic sys_clk_lf_sel_out,
   output logic [1:0] output_flipflop_ctl_out
);
   owc_pkg::owc_state_t s, n;
   owc_tick_if tick_if ();
   logic run;
   logic cfg_ok;
   logic hit;

   owc_prescaler #(
      .FC_CYC(FC_CYC),
      .FS_CYC(FS_CYC)
   ) u_pre (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .tick_if(tick_if)
   );

   assign tick_if.clk_sel = s.lctl[`OWC_SRC_MSB:`OWC_SRC_LSB];

   always_comb begin
      n = s;
      n.match = 1'b0;
      n.rdata = 8'h00;
      run = s.uctl[`OWC_RUN_BIT];
      cfg_ok = (s.uctl[`OWC_MODE_MSB:0] == `OWC_WARMUP_MODE) &&
         (s.lctl[`OWC_MODE_MSB:0] == `OWC_CASCADE_MODE);
      // lower compare byte is never looked at in this mode
      hit = (16'(s.count + 16'h0001) == {s.ucmp, 8'h00});

      case (s.phase)
         owc_pkg::owc_idle: begin
            n.count = 16'h0000;
            if (run && cfg_ok) begin
               n.phase = owc_pkg::owc_count;
            end
         end
         owc_pkg::owc_count: begin
            if (!run || !cfg_ok) begin
               n.phase = owc_pkg::owc_idle;
               n.count = 16'h0000;
            end else if (tick_if.tick) begin
               if (hit) begin
                  n.count = 16'h0000;
                  n.match = 1'b1;
               end else begin
                  n.count = 16'(s.count + 16'h0001);
               end
            end
         end
         default: begin
            n.phase = owc_pkg::owc_idle;
            n.count = 16'h0000;
         end
      endcase

      if (reg_wr_in) begin
         case (reg_addr_in)
            `OWC_LCTL_OFS: n.lctl = reg_wdata_in;
            `OWC_UCTL_OFS: n.uctl = reg_wdata_in;
            `OWC_LCMP_OFS: n.lcmp = reg_wdata_in;
            `OWC_UCMP_OFS: n.ucmp = reg_wdata_in;
            `OWC_SYSCTL_OFS: n.sysctl = reg_wdata_in;
            `OWC_MASK_OFS: n.mask = reg_wdata_in;
            default: n.sysctl = n.sysctl;
         endcase
      end

      if (reg_rd_in) begin
         case (reg_addr_in)
            `OWC_LCTL_OFS: n.rdata = s.lctl;
            `OWC_UCTL_OFS: n.rdata = s.uctl;
            `OWC_LCMP_OFS: n.rdata = s.lcmp;
            `OWC_UCMP_OFS: n.rdata = s.ucmp;
            `OWC_SYSCTL_OFS: n.rdata = s.sysctl;
            `OWC_STATUS_OFS: n.rdata = s.status;
            `OWC_MASK_OFS: n.rdata = s.mask;
            `OWC_CNTLO_OFS: n.rdata = s.count[7:0];
            `OWC_CNTHI_OFS: n.rdata = s.count[15:8];
            default: n.rdata = 8'h00;
         endcase
      end

      // a match landing on the clearing read still sets the flag
      if (reg_rd_in && reg_addr_in == `OWC_STATUS_OFS) begin
         n.status = 8'h00;
      end
      n.status[`OWC_MATCH_BIT] = n.status[`OWC_MATCH_BIT] | n.match;
      n.irq = |(n.status & n.mask);
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s.phase <= owc_pkg::owc_idle;
         s.count <= 16'h0000;
         s.lctl <= `OWC_CTL_RST;
         s.uctl <= `OWC_CTL_RST;
         s.lcmp <= `OWC_CMP_RST;
         s.ucmp <= `OWC_CMP_RST;
         s.sysctl <= `OWC_SYSCTL_RST;
         s.status <= 8'h00;
         s.mask <= `OWC_MASK_RST;
         s.rdata <= 8'h00;
         s.irq <= 1'b0;
         s.match <= 1'b0;
      end else begin
         s <= n;
      end
   end

   assign reg_rdata_out = s.rdata;
   assign irq_out = s.irq;
   assign warmup_match_irq_out = s.match;
   assign hf_osc_en_out = s.sysctl[`OWC_HFEN_BIT];
   assign lf_osc_en_out = s.sysctl[`OWC_LFEN_BIT];
   assign sys_clk_lf_sel_out = s.sysctl[`OWC_LFSEL_BIT];
   // pins follow the bits; keeping them low is up to software
   assign output_flipflop_ctl_out = {s.uctl[`OWC_FLIPFLOP_BIT], s.lctl[`OWC_FLIPFLOP_BIT]};

   // helper: cycles between ticks while the source stays put
   logic [15:0] gap_reg;
   logic gap_ok_reg;
   logic [2:0] sel_d_reg;
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         gap_reg <= 16'h0000;
         gap_ok_reg <= 1'b0;
         sel_d_reg <= 3'h0;
      end else begin
         sel_d_reg <= tick_if.clk_sel;
         gap_reg <= tick_if.tick ? 16'h0000 : 16'(gap_reg + 16'h0001);
         if (sel_d_reg != tick_if.clk_sel) begin
            gap_ok_reg <= 1'b0;
         end else if (tick_if.tick) begin
            gap_ok_reg <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   count_step_a: assert property (s.phase == owc_pkg::owc_count && run && cfg_ok && tick_if.tick && !hit
      |=> s.count == 16'($past(s.count) + 16'h0001))
      else $error("counter did not step by one");

   upper_only_a: assert property (s.match
      |-> $past(s.count) == 16'({$past(s.ucmp), 8'h00} - 16'h0001))
      else $error("match not at upper compare byte");

   start_zero_a: assert property (reg_wr_in && reg_addr_in == `OWC_UCTL_OFS && reg_wdata_in[`OWC_RUN_BIT]
      && s.phase == owc_pkg::owc_idle |=> s.count == 16'h0000 ##1 s.count == 16'h0000)
      else $error("start did not begin from zero");

   match_clear_a: assert property (s.match |-> s.count == 16'h0000 && s.status[`OWC_MATCH_BIT]
      ##1 (irq_out || !s.mask[`OWC_MATCH_BIT] || $past(reg_rd_in)))
      else $error("match did not clear and flag");

   stop_clear_a: assert property (s.phase == owc_pkg::owc_count && !s.uctl[`OWC_RUN_BIT]
      |=> s.count == 16'h0000 && s.phase == owc_pkg::owc_idle)
      else $error("stop did not clear counter");

   sysctl_bits_a: assert property (reg_wr_in && reg_addr_in == `OWC_SYSCTL_OFS
      |=> hf_osc_en_out == $past(reg_wdata_in[7]) && lf_osc_en_out == $past(reg_wdata_in[6])
      && sys_clk_lf_sel_out == $past(reg_wdata_in[5]))
      else $error("system control bits misplaced");

   mode_gate_a: assert property (!cfg_ok |=> s.count == 16'h0000)
      else $error("counting outside warm-up mode");

   fs_period_a: assert property (tick_if.tick && gap_ok_reg && sel_d_reg == `OWC_SRC_FS
      |-> gap_reg == 16'(FS_CYC - 1))
      else $error("fs tick period wrong");

   fc_period_a: assert property (tick_if.tick && gap_ok_reg && sel_d_reg == `OWC_SRC_FC
      |-> gap_reg == 16'(FC_CYC - 1))
      else $error("fc tick period wrong");

   match_seen_c: cover property (s.match);
   stop_run_c: cover property (s.phase == owc_pkg::owc_count && !s.uctl[`OWC_RUN_BIT]);
   irq_read_c: cover property (irq_out ##[1:50] reg_rd_in && reg_addr_in == `OWC_STATUS_OFS);
   fc_half_c: cover property (tick_if.tick && sel_d_reg == `OWC_SRC_FC1);
   mode_wrong_c: cover property (run && !cfg_ok);
endmodule

// ==== verilog/owc_map.svh ====
`ifndef OWC_MAP_SVH
`define OWC_MAP_SVH

// register offsets
`define OWC_LCTL_OFS 4'h0
`define OWC_UCTL_OFS 4'h1
`define OWC_LCMP_OFS 4'h2
`define OWC_UCMP_OFS 4'h3
`define OWC_SYSCTL_OFS 4'h4
`define OWC_STATUS_OFS 4'h5
`define OWC_MASK_OFS 4'h6
`define OWC_CNTLO_OFS 4'h7
`define OWC_CNTHI_OFS 4'h8

// field positions
`define OWC_RUN_BIT 3
`define OWC_FLIPFLOP_BIT 7
`define OWC_MODE_MSB 2
`define OWC_SRC_MSB 6
`define OWC_SRC_LSB 4
`define OWC_HFEN_BIT 7
`define OWC_LFEN_BIT 6
`define OWC_LFSEL_BIT 5
`define OWC_MATCH_BIT 0

// field codes
`define OWC_WARMUP_MODE 3'h5
`define OWC_CASCADE_MODE 3'h3
`define OWC_SRC_FC11 3'h0
`define OWC_SRC_FC7 3'h1
`define OWC_SRC_FC5 3'h2
`define OWC_SRC_FC3 3'h3
`define OWC_SRC_FS 3'h4
`define OWC_SRC_FC1 3'h5
`define OWC_SRC_FC 3'h6

// reset values
`define OWC_CTL_RST 8'h00
`define OWC_CMP_RST 8'h00
`define OWC_SYSCTL_RST 8'h80
`define OWC_MASK_RST 8'h00

// timing
`define OWC_CLK_HZ 100000000
`define OWC_FS_HZ 32768
`define OWC_FC_HZ 16000000
`define OWC_FS_CYC (`OWC_CLK_HZ / `OWC_FS_HZ)
`define OWC_FC_CYC (`OWC_CLK_HZ / `OWC_FC_HZ)

`endif

// ==== verilog/owc_pkg.sv ====
package owc_pkg;

   typedef enum logic {owc_idle, owc_count} owc_phase_t;

   typedef struct packed {
      owc_phase_t phase;
      logic [15:0] count;
      logic [7:0] lctl;
      logic [7:0] uctl;
      logic [7:0] lcmp;
      logic [7:0] ucmp;
      logic [7:0] sysctl;
      logic [7:0] status;
      logic [7:0] mask;
      logic [7:0] rdata;
      logic irq;
      logic match;
   } owc_state_t;

   typedef struct packed {
      logic [15:0] fc_div;
      logic [15:0] fs_div;
      logic [10:0] pre;
      logic tick;
   } owc_pre_state_t;

endpackage

// ==== verilog/owc_tick_if.sv ====
`timescale 1ns/100ps
interface owc_tick_if;
   logic [2:0] clk_sel;
   logic tick;
   modport src (input clk_sel, output tick);
   modport user (output clk_sel, input tick);
endinterface

// ==== verilog/owc_prescaler.sv ====
`timescale 1ns/100ps
`include "owc_map.svh"
module owc_prescaler #(
   parameter int FC_CYC = `OWC_FC_CYC,
   parameter int FS_CYC = `OWC_FS_CYC
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   owc_tick_if.src tick_if
);
   owc_pkg::owc_pre_state_t s, n;
   logic fc_t;
   logic fs_t;

   // dividers run free so every source keeps an exact period across starts
   always_comb begin
      n = s;
      fc_t = (s.fc_div == 16'(FC_CYC - 1));
      fs_t = (s.fs_div == 16'(FS_CYC - 1));
      n.fc_div = fc_t ? 16'h0000 : 16'(s.fc_div + 16'h0001);
      n.fs_div = fs_t ? 16'h0000 : 16'(s.fs_div + 16'h0001);
      if (fc_t) begin
         n.pre = 11'(s.pre + 11'h001);
      end
      case (tick_if.clk_sel)
         `OWC_SRC_FC11: n.tick = fc_t && (&s.pre[10:0]);
         `OWC_SRC_FC7: n.tick = fc_t && (&s.pre[6:0]);
         `OWC_SRC_FC5: n.tick = fc_t && (&s.pre[4:0]);
         `OWC_SRC_FC3: n.tick = fc_t && (&s.pre[2:0]);
         `OWC_SRC_FS: n.tick = fs_t;
         `OWC_SRC_FC1: n.tick = fc_t && s.pre[0];
         `OWC_SRC_FC: n.tick = fc_t;
         default: n.tick = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tick_if.tick = s.tick;

   tick_single_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      s.tick && tick_if.clk_sel != `OWC_SRC_FC1 |=> !s.tick)
      else $error("tick lasted more than one cycle");
endmodule

// ==== verif/tb_owc_top.sv ====
`timescale 1ns/100ps
`include "owc_map.svh"
module tb_owc_top;
   // short tick dividers keep the run brief; every expected time scales from these
   localparam int FC = 2;
   localparam int FS = 4;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [3:0] a = 4'h0;
   logic [7:0] wd = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdat;
   logic irq;
   logic mirq;
   logic hfen;
   logic lfen;
   logic lfsel;
   logic [1:0] tff;
   int fails = 0;
   int checks_done = 0;
   int n;

   owc_top #(.FC_CYC(FC), .FS_CYC(FS)) dut_u (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .reg_addr_in(a),
      .reg_wdata_in(wd),
      .reg_wr_in(wr),
      .reg_rd_in(rd),
      .reg_rdata_out(rdat),
      .irq_out(irq),
      .warmup_match_irq_out(mirq),
      .hf_osc_en_out(hfen),
      .lf_osc_en_out(lfen),
      .sys_clk_lf_sel_out(lfsel),
      .output_flipflop_ctl_out(tff)
   );

   initial begin
      forever #5 core_clk_in = ~core_clk_in;
   end

   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
      @(posedge core_clk_in);
      wr <= 1'b1;
      a <= ad;
      wd <= d;
      @(posedge core_clk_in);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the read edge
   task automatic rchk(input string what, input logic [3:0] ad, input logic [7:0] exp);
      @(posedge core_clk_in);
      rd <= 1'b1;
      a <= ad;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1;
      chk(what, {8'h00, rdat}, {8'h00, exp});
   endtask

   task automatic outs(input logic [2:0] exp);
      #1;
      chk("osc outputs", {13'h0000, hfen, lfen, lfsel}, {13'h0000, exp});
   endtask

   task automatic t_reset;
      outs(3'b100);
      chk("irq and flip-flops", {12'h000, irq, mirq, tff}, 16'h0000);
      rchk("sysctl reset", `OWC_SYSCTL_OFS, `OWC_SYSCTL_RST);
      rchk("status reset", `OWC_STATUS_OFS, 8'h00);
      rchk("unmapped", 4'hf, 8'h00);
      wreg(`OWC_STATUS_OFS, 8'hff);
      rchk("status read only", `OWC_STATUS_OFS, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_ctl;
      wreg(`OWC_SYSCTL_OFS, 8'h60);
      outs(3'b011);
      wreg(`OWC_SYSCTL_OFS, 8'h80);
      outs(3'b100);
      wreg(`OWC_LCTL_OFS, 8'h80);
      #1;
      chk("flip-flop bits", {14'h0000, tff}, 16'h0001);
      wreg(`OWC_UCTL_OFS, 8'h80);
      #1;
      chk("upper flip-flop bit", {14'h0000, tff}, 16'h0003);
      wreg(`OWC_UCTL_OFS, 8'h00);
      wreg(`OWC_LCTL_OFS, 8'h00);
      $display("test control bits done");
   endtask

   // lower compare byte set to ff: if it took part, each match would come 255 ticks later
   task automatic t_warm(input logic [7:0] lctl, input logic [7:0] cmp, input int p, input logic m);
      int exp;
      exp = 256 * cmp * p;
      wreg(`OWC_LCTL_OFS, lctl);
      wreg(`OWC_UCTL_OFS, 8'h05);
      wreg(`OWC_LCMP_OFS, 8'hff);
      wreg(`OWC_UCMP_OFS, cmp);
      wreg(`OWC_MASK_OFS, {7'h00, m});
      wreg(`OWC_UCTL_OFS, 8'h0d);
      n = 0;
      while (n < 5000) begin
         @(posedge core_clk_in);
         #1;
         n++;
         if (mirq === 1'b1) break;
      end
      chk("match time", {15'h0000, n >= exp - p && n <= exp + p + 3}, 16'h0001);
      chk("irq level", {15'h0000, irq}, {15'h0000, m});
      chk("flip-flops held low", {14'h0000, tff}, 16'h0000);
      @(posedge core_clk_in);
      #1;
      chk("match pulse", {15'h0000, mirq}, 16'h0000);
      rchk("count cleared", `OWC_CNTHI_OFS, 8'h00);
      rchk("status set", `OWC_STATUS_OFS, 8'h01);
      rchk("status cleared", `OWC_STATUS_OFS, 8'h00);
      chk("irq dropped", {15'h0000, irq}, 16'h0000);
      wreg(`OWC_UCTL_OFS, 8'h05);
      rchk("stopped low", `OWC_CNTLO_OFS, 8'h00);
      rchk("stopped high", `OWC_CNTHI_OFS, 8'h00);
      $display("test warm-up done");
   endtask

   task automatic t_mode;
      wreg(`OWC_LCTL_OFS, 8'h43);
      wreg(`OWC_UCTL_OFS, 8'h0c);
      repeat (100) @(posedge core_clk_in);
      rchk("wrong mode low", `OWC_CNTLO_OFS, 8'h00);
      rchk("wrong mode high", `OWC_CNTHI_OFS, 8'h00);
      wreg(`OWC_UCTL_OFS, 8'h04);
      $display("test wrong mode done");
   endtask

   // reset in mid-count must drop every register back, counter included
   task automatic t_rst;
      wreg(`OWC_SYSCTL_OFS, 8'h60);
      wreg(`OWC_LCTL_OFS, 8'h43);
      wreg(`OWC_UCTL_OFS, 8'h0d);
      repeat (50) @(posedge core_clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      outs(3'b100);
      rchk("reset upper control", `OWC_UCTL_OFS, 8'h00);
      rchk("reset count", `OWC_CNTLO_OFS, 8'h00);
      $display("test mid-run reset done");
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // whole run is under ten thousand cycles; this is twice that
   initial begin
      #200000;
      fails++;
      $display("unexpected at %0t: run hung", $time);
      give_verdict;
   end

   initial begin
      repeat (4) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge core_clk_in);
      t_reset;
      t_ctl;
      wreg(`OWC_SYSCTL_OFS, 8'hc0);
      t_warm(8'h43, 8'h01, FS, 1'b1);
      wreg(`OWC_SYSCTL_OFS, 8'he0);
      wreg(`OWC_SYSCTL_OFS, 8'h60);
      outs(3'b011);
      wreg(`OWC_SYSCTL_OFS, 8'he0);
      t_warm(8'h63, 8'h02, FC, 1'b0);
      t_warm(8'h53, 8'h01, 2 * FC, 1'b1);
      t_warm(8'h33, 8'h01, 8 * FC, 1'b0);
      wreg(`OWC_SYSCTL_OFS, 8'hc0);
      wreg(`OWC_SYSCTL_OFS, 8'h80);
      outs(3'b100);
      t_mode;
      t_rst;
      give_verdict;
   end
endmodule
